// [hbap_port.sv]
// host parallel port with strobe style and bus type autodetect
//
// Summary of operation
// - 8-bit data bus, register address lines and control strobes face the host.
// - after reset detect strobe style; assume separate read/write strobes until then.
// - detected strobe style holds until the next hardware reset.
// - lowest address line activity means non-multiplexed; multiplexed is default.
// - chip select with read freezes both decisions until hardware reset.
// - registers decoded directly; RAM reached via pointer and data register, no waits.
// - pointer either auto-increments or stays fixed.
// - writing pointer low byte for reads prefetches the addressed RAM byte.
// - with a fixed pointer, reading data register does not fetch fresh RAM contents.
// - host write to data register latches byte, then stores it at pointer.
// - diagnostic read clears it; RAM and next-id reads have side effects too.
// - fast mode captures address and chip select on first delayed read edge.
// - fast mode qualified read starts on second delay, ends on undelayed strobe.
// - data output path uses unsampled address, chip select and undelayed strobe.
// - read pulse generator gives diagnostic clear and RAM arbitration start pulses.
// - first read delay 15 ns, second 10 ns, each rounded up to one 50 ns clock cycle.
// - pin 0 fast read/write; pin 1 with bit 0 normal; bit 1 fast read only.
// - without the timing pin it acts as tied to 1.
// - same sampling and delaying applies to direction and data strobe style.
`timescale 1ns/100ps
`default_nettype none
module hbap_port #(
  parameter int RAM_AW = 11
) (
  input wire logic mclk, // 20 MHz clock
  input wire logic rst_b, // async reset, active low
  input wire logic chip_select_n, // chip select, low
  input wire logic read_strobe_n, // read strobe, or data strobe in direction style
  input wire logic write_strobe_n, // write strobe, or direction (1 read) in direction style
  input wire logic [2:0] register_addr_lines, // register address
  input wire logic [7:0] data_in, // data bus input
  input wire logic fast_timing_pin, // 0 fast read and write; tie 1 if absent
  input wire logic [7:0] diagnostic_status_reg_events, // diagnostic event set pulses
  input wire logic [7:0] next_node_id, // next node identifier
  output logic [7:0] data_out, // data bus output
  output logic data_oe, // data bus drive enable, high
  output hbap_pkg::hbap_mode_t mode, // detected interface mode
  output logic diagnostic_status_reg_clear, // diagnostic clear pulse
  output logic ram_arb_start, // RAM arbitration start pulse
  output logic next_id_read // next-id read side effect pulse
);
  import hbap_pkg::*;

  // ----------------------------------------------------------------
  // strobe decode
  // ----------------------------------------------------------------
  logic rd_raw;
  logic wr_raw;
  logic cs;
  assign cs = ~chip_select_n;
  // a read needs the write/direction pin high in both styles: an undetected data strobe write never reads
  assign rd_raw = ~read_strobe_n & write_strobe_n;
  assign wr_raw = mode.dir_strobe_style ? (~read_strobe_n & ~write_strobe_n) : ~write_strobe_n;

  // ----------------------------------------------------------------
  // mode detection
  // ----------------------------------------------------------------
  hbap_mode_t next_mode;
  always_comb begin
    next_mode = mode;
    if (!mode.frozen) begin
      // both strobes low is only possible with a data strobe write
      if (~read_strobe_n & ~write_strobe_n) begin
        next_mode.dir_strobe_style = 1'b1;
      end
      if (cs & register_addr_lines[0]) begin
        next_mode.non_muxed = 1'b1;
      end
      if (cs & rd_raw) begin
        next_mode.frozen = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // fast timing and delayed strobes
  // ----------------------------------------------------------------
  logic cfg_fast_rd;
  logic fast_rd;
  logic fast_wr;
  logic rd_d1;
  logic rd_d2;
  assign fast_rd = ~fast_timing_pin | cfg_fast_rd;
  assign fast_wr = ~fast_timing_pin;

  hbap_rd_delay #(
    .DLY1(HBAP_RD_DLY1_CYC),
    .DLY2(HBAP_RD_DLY2_CYC)
  ) u_dly (
    .mclk(mclk),
    .rst_b(rst_b),
    .rd_act(rd_raw),
    .read_delay_first(rd_d1),
    .read_delay_second(rd_d2)
  );

  hbap_acc_t samp;
  hbap_acc_t next_samp;
  hbap_acc_t raw_acc;
  logic rd_d1_q;
  assign raw_acc = '{sel: cs, addr: register_addr_lines};

  always_comb begin
    next_samp = samp;
    if (rd_d1 & ~rd_d1_q) begin
      next_samp = raw_acc;
    end else if (fast_wr & wr_raw & ~samp.sel) begin
      next_samp = raw_acc;
    end else if (~rd_raw & ~wr_raw) begin
      next_samp = '0;
    end
  end

  // qualified read: fast starts on second delay and ends with the host strobe
  logic rd_q;
  logic rd_q_prev;
  logic rd_pulse;
  hbap_acc_t rd_acc;
  assign rd_q = fast_rd ? (rd_d2 & samp.sel) : (rd_raw & cs);
  assign rd_acc = fast_rd ? samp : raw_acc;
  assign rd_pulse = rd_q & ~rd_q_prev;

  // writes commit on the trailing edge of the host write
  logic wr_prev;
  hbap_acc_t wr_acc;
  hbap_acc_t next_wr_acc;
  logic [7:0] wr_data;
  logic [7:0] next_wr_data;
  logic wr_commit;
  assign wr_commit = wr_prev & ~wr_raw & wr_acc.sel;

  always_comb begin
    next_wr_acc = wr_acc;
    next_wr_data = wr_data;
    if (wr_raw) begin
      // fast write: first cycle takes the live address, later cycles the sampled one
      next_wr_acc = (fast_wr & samp.sel) ? samp : raw_acc;
      next_wr_data = data_in;
    end else if (!wr_prev) begin
      next_wr_acc = '0;
    end
  end

  // ----------------------------------------------------------------
  // registers and RAM
  // ----------------------------------------------------------------
  logic [7:0] ram [0:(1<<RAM_AW)-1];
  logic [7:0] diagnostic_status_reg;
  logic [7:0] next_diagnostic_status_reg;
  logic [7:0] cfg;
  logic [7:0] next_cfg;
  logic [7:0] ptr_hi;
  logic [7:0] next_ptr_hi;
  logic [RAM_AW-1:0] ptr;
  logic [RAM_AW-1:0] next_ptr;
  logic [7:0] data_reg;
  logic [7:0] next_data_reg;
  logic pf_pend;
  logic next_pf_pend;
  logic st_pend;
  logic next_st_pend;
  logic inc_pend;
  logic next_inc_pend;
  logic auto_inc;
  logic ptr_rd;
  assign cfg_fast_rd = cfg[HBAP_CFG_FAST_RD_BIT];
  assign auto_inc = ptr_hi[HBAP_PTR_HI_INC_BIT];
  assign ptr_rd = ptr_hi[HBAP_PTR_HI_RD_BIT];

  function automatic logic hit(input hbap_acc_t a, input logic [2:0] r);
    hit = a.sel & (a.addr == r);
  endfunction : hit

  always_comb begin
    next_diagnostic_status_reg = diagnostic_status_reg;
    next_cfg = cfg;
    next_ptr_hi = ptr_hi;
    next_ptr = ptr;
    next_data_reg = data_reg;
    next_pf_pend = 1'b0;
    next_st_pend = 1'b0;
    next_inc_pend = 1'b0;
    if (rd_pulse & hit(rd_acc, HBAP_REG_DIAGNOSTIC_STATUS_REG)) begin
      next_diagnostic_status_reg = HBAP_DIAGNOSTIC_STATUS_REG_RST;
    end
    next_diagnostic_status_reg = next_diagnostic_status_reg | diagnostic_status_reg_events; // set wins over the read clear
    if (wr_commit) begin
      case (wr_acc.addr)
        HBAP_REG_PTR_LO: begin
          next_ptr = {ptr[RAM_AW-1:8], wr_data};
          next_pf_pend = ptr_rd;
        end
        HBAP_REG_PTR_HI: begin
          next_ptr_hi = wr_data;
          next_ptr = {wr_data[RAM_AW-9:0], ptr[7:0]};
        end
        HBAP_REG_DATA: begin
          next_data_reg = wr_data;
          next_st_pend = 1'b1;
        end
        HBAP_REG_CFG: begin
          next_cfg = wr_data;
        end
        default: begin
        end
      endcase
    end
    // a data read with a fixed pointer leaves the data register alone
    if (rd_pulse & hit(rd_acc, HBAP_REG_DATA) & auto_inc) begin
      next_inc_pend = 1'b1;
    end
    if (st_pend) begin
      next_inc_pend = auto_inc;
    end
    if (inc_pend) begin
      next_ptr = ptr + 1'b1;
      next_pf_pend = ptr_rd;
    end
    if (pf_pend) begin
      next_data_reg = ram[ptr];
    end
  end

  always_ff @(posedge mclk) begin
    if (st_pend) begin
      ram[ptr] <= data_reg;
    end
  end

  // ----------------------------------------------------------------
  // output path: unsampled address and undelayed strobe
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    case (register_addr_lines)
      HBAP_REG_DIAGNOSTIC_STATUS_REG: rd_mux = diagnostic_status_reg;
      HBAP_REG_PTR_LO: rd_mux = ptr[7:0];
      HBAP_REG_PTR_HI: rd_mux = ptr_hi;
      HBAP_REG_DATA: rd_mux = data_reg;
      HBAP_REG_CFG: rd_mux = cfg;
      HBAP_REG_NEXT_ID: rd_mux = next_node_id;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= '0;
      samp <= '0;
      rd_d1_q <= 1'b0;
      rd_q_prev <= 1'b0;
      wr_prev <= 1'b0;
      wr_acc <= '0;
      wr_data <= 8'h00;
      diagnostic_status_reg <= HBAP_DIAGNOSTIC_STATUS_REG_RST;
      cfg <= HBAP_CFG_RST;
      ptr_hi <= HBAP_PTR_HI_RST;
      ptr <= '0;
      data_reg <= 8'h00;
      pf_pend <= 1'b0;
      st_pend <= 1'b0;
      inc_pend <= 1'b0;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      diagnostic_status_reg_clear <= 1'b0;
      ram_arb_start <= 1'b0;
      next_id_read <= 1'b0;
    end else begin
      mode <= next_mode;
      samp <= next_samp;
      rd_d1_q <= rd_d1;
      rd_q_prev <= rd_q;
      wr_prev <= wr_raw;
      wr_acc <= next_wr_acc;
      wr_data <= next_wr_data;
      diagnostic_status_reg <= next_diagnostic_status_reg;
      cfg <= next_cfg;
      ptr_hi <= next_ptr_hi;
      ptr <= next_ptr;
      data_reg <= next_data_reg;
      pf_pend <= next_pf_pend;
      st_pend <= next_st_pend;
      inc_pend <= next_inc_pend;
      data_out <= rd_mux;
      data_oe <= cs & rd_raw;
      diagnostic_status_reg_clear <= rd_pulse & hit(rd_acc, HBAP_REG_DIAGNOSTIC_STATUS_REG);
      ram_arb_start <= rd_pulse & hit(rd_acc, HBAP_REG_DATA);
      next_id_read <= rd_pulse & hit(rd_acc, HBAP_REG_NEXT_ID);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_ptr_load;
    wr_commit && wr_acc.addr == HBAP_REG_PTR_LO && ptr_rd;
  endsequence

  property p_prefetch;
    @(posedge mclk) disable iff (!rst_b)
      s_ptr_load ##1 pf_pend |=> data_reg == $past(ram[ptr]);
  endproperty

  a_style_sticky: assert property (@(posedge mclk) disable iff (!rst_b)
    mode.dir_strobe_style |=> mode.dir_strobe_style) else $error("strobe style dropped");
  a_freeze_read: assert property (@(posedge mclk) disable iff (!rst_b)
    (cs && rd_raw) |=> mode.frozen) else $error("read did not freeze mode");
  a_frozen_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    mode.frozen |=> $stable(mode.non_muxed) && $stable(mode.dir_strobe_style)) else $error("mode moved");
  a_mux_detect: assert property (@(posedge mclk) disable iff (!rst_b)
    (!mode.frozen && cs && register_addr_lines[0]) |=> mode.non_muxed) else $error("bus type missed");
  a_ptr_prefetch: assert property (p_prefetch) else $error("prefetch wrong");
  a_no_refetch: assert property (@(posedge mclk) disable iff (!rst_b)
    (rd_pulse && hit(rd_acc, HBAP_REG_DATA) && !auto_inc && !pf_pend && !wr_commit)
      |=> $stable(data_reg)) else $error("data register refetched");
  a_data_store: assert property (@(posedge mclk) disable iff (!rst_b)
    st_pend |=> ram[$past(ptr)] == $past(data_reg)) else $error("store missed");
  a_auto_inc: assert property (@(posedge mclk) disable iff (!rst_b)
    inc_pend && !wr_commit |=> ptr == $past(ptr) + 1'b1) else $error("pointer not advanced");
  a_diagnostic_status_reg_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    (rd_pulse && hit(rd_acc, HBAP_REG_DIAGNOSTIC_STATUS_REG) && diagnostic_status_reg_events == 8'h00)
      |=> diagnostic_status_reg == 8'h00 && diagnostic_status_reg_clear) else $error("diagnostic_status_reg not cleared");
  a_fast_sample: assert property (@(posedge mclk) disable iff (!rst_b)
    (rd_d1 && !rd_d1_q) |=> samp == $past(raw_acc)) else $error("address not sampled");
  a_fast_end: assert property (@(posedge mclk) disable iff (!rst_b)
    (fast_rd && !rd_raw) |-> !rd_q ##1 !ram_arb_start [*2]) else $error("read outlived strobe");
  a_oe_follow: assert property (@(posedge mclk) disable iff (!rst_b)
    (cs && rd_raw) |=> data_oe) else $error("output not enabled");
  a_oe_write_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_raw |=> !data_oe) else $error("output driven during write");
endmodule : hbap_port
`default_nettype wire

// [hbap_pkg.sv]
// package: constants and carrier types for the host bus autodetect port
package hbap_pkg;
  // ----------------------------------------------------------------
  // register map (register_addr_lines)
  // ----------------------------------------------------------------
  localparam logic [2:0] HBAP_REG_DIAGNOSTIC_STATUS_REG = 3'h0;
  localparam logic [2:0] HBAP_REG_PTR_LO = 3'h1;
  localparam logic [2:0] HBAP_REG_PTR_HI = 3'h2;
  localparam logic [2:0] HBAP_REG_DATA = 3'h3;
  localparam logic [2:0] HBAP_REG_CFG = 3'h4;
  localparam logic [2:0] HBAP_REG_NEXT_ID = 3'h5;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int HBAP_PTR_HI_RD_BIT = 7;
  localparam int HBAP_PTR_HI_INC_BIT = 6;
  localparam int HBAP_CFG_FAST_RD_BIT = 0;
  localparam logic [7:0] HBAP_DIAGNOSTIC_STATUS_REG_RST = 8'h00;
  localparam logic [7:0] HBAP_CFG_RST = 8'h00;
  localparam logic [7:0] HBAP_PTR_HI_RST = 8'h00;
  localparam logic [7:0] HBAP_PTR_LO_RST = 8'h00;
  // ----------------------------------------------------------------
  // timing: internal read strobe delays
  // ----------------------------------------------------------------
  localparam int HBAP_CLK_PERIOD_NS = 50;
  localparam int HBAP_RD_DLY1_NS = 15;
  localparam int HBAP_RD_DLY2_NS = 10;
  localparam int HBAP_RD_DLY1_CYC = (HBAP_RD_DLY1_NS + HBAP_CLK_PERIOD_NS - 1) / HBAP_CLK_PERIOD_NS;
  localparam int HBAP_RD_DLY2_CYC = (HBAP_RD_DLY2_NS + HBAP_CLK_PERIOD_NS - 1) / HBAP_CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sel;
    logic [2:0] addr;
  } hbap_acc_t;
  typedef struct packed {
    logic dir_strobe_style;
    logic non_muxed;
    logic frozen;
  } hbap_mode_t;
endpackage : hbap_pkg

// [hbap_rd_delay.sv]
// delayed copies of the raw host read strobe (not qualified by chip select)
`timescale 1ns/100ps
`default_nettype none
module hbap_rd_delay #(
  parameter int DLY1 = hbap_pkg::HBAP_RD_DLY1_CYC,
  parameter int DLY2 = hbap_pkg::HBAP_RD_DLY2_CYC
) (
  input wire logic mclk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic rd_act, // undelayed read active, high
  output logic read_delay_first, // first delayed read, high
  output logic read_delay_second // second delayed read, high
);
  import hbap_pkg::*;
  logic [DLY1+DLY2-1:0] tap;
  logic [DLY1+DLY2-1:0] next_tap;

  // the chain empties as soon as the strobe ends, so a read that follows one idle cycle later starts from scratch
  always_comb begin
    next_tap = rd_act ? {tap[DLY1+DLY2-2:0], 1'b1} : '0;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tap <= '0;
    end else begin
      tap <= next_tap;
    end
  end

  // the rising edge of the host strobe is not delayed: both taps drop with it
  assign read_delay_first = tap[DLY1-1] & rd_act;
  assign read_delay_second = tap[DLY1+DLY2-1] & rd_act;
endmodule : hbap_rd_delay
`default_nettype wire

// [hbap_host_model.sv]
// host bus master model: drives the port strobes the way a microcontroller would
`timescale 1ns/100ps
`default_nettype none
module hbap_host_model (
  input wire logic mclk, // system clock
  input wire logic [7:0] data_out, // device read data
  input wire logic [2:0] pulses, // diagnostic_status_reg clear, ram arb start, next id read
  output var logic chip_select_n, // chip select, low
  output var logic read_strobe_n, // read or data strobe
  output var logic write_strobe_n, // write strobe or direction
  output var logic [2:0] register_addr_lines, // register address
  output var logic [7:0] data_in // write data
);
  logic dir_style;
  initial begin
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    register_addr_lines = 3'h0;
    data_in = 8'h00;
    dir_style = 1'b0;
  end
  // ----------------------------------------------------------------
  // one access: hold is the strobe width in cycles
  // ----------------------------------------------------------------
  task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d, input int hold,
                        output logic [7:0] q, output logic [2:0] seen);
    seen = 3'h0;
    q = 8'h00;
    @(negedge mclk);
    chip_select_n <= 1'b0;
    register_addr_lines <= a;
    data_in <= d;
    read_strobe_n <= dir_style ? 1'b0 : wr;
    write_strobe_n <= !wr;
    for (int i = 0; i < hold; i++) begin
      @(negedge mclk);
      if (i == 0) q = data_out;
      seen |= pulses;
    end
    chip_select_n <= 1'b1;
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    data_in <= ~d; // released bus does not keep its last value
    // idle gap also covers the auto-increment spacing
    repeat (5) begin
      @(negedge mclk);
      seen |= pulses;
    end
  endtask : access
  // write then read an odd location before real traffic
  task automatic init();
    logic [7:0] q;
    logic [2:0] s;
    access(1'b1, 3'h1, 8'h00, 1, q, s);
    access(1'b0, 3'h1, 8'h00, 2, q, s);
  endtask : init
endmodule : hbap_host_model
`default_nettype wire

// [hbap_port_tb_top.sv]
// self-checking testbench for the host bus autodetect port
`timescale 1ns/100ps
`default_nettype none
module hbap_port_tb_top;
  import hbap_pkg::*;
  logic mclk, rst_b, cs_n, rd_n, wr_n, pin, oe, dclr, arb, nidr;
  logic [2:0] a, seen;
  logic [7:0] din, ev, nid, dout, q;
  hbap_mode_t mode;
  int bad_count, n_compared;
  // ----------------------------------------------------------------
  // clock, instances
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  hbap_port i_hbap_port (.mclk(mclk), .rst_b(rst_b), .chip_select_n(cs_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .register_addr_lines(a), .data_in(din), .fast_timing_pin(pin),
    .diagnostic_status_reg_events(ev), .next_node_id(nid), .data_out(dout), .data_oe(oe), .mode(mode),
    .diagnostic_status_reg_clear(dclr), .ram_arb_start(arb), .next_id_read(nidr));
  hbap_host_model i_hbap_host_model (.mclk(mclk), .data_out(dout), .pulses({dclr, arb, nidr}),
    .chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .register_addr_lines(a),
    .data_in(din));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen_v, input logic [7:0] exp_v);
    n_compared++;
    if (seen_v !== exp_v) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp_v, seen_v);
    end
  endtask : check
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    i_hbap_host_model.access(1'b1, ad, d, 1, q, seen);
  endtask : wr
  task automatic rd(input logic [2:0] ad, input int hold);
    i_hbap_host_model.access(1'b0, ad, 8'h00, hold, q, seen);
  endtask : rd
  task automatic do_reset();
    @(negedge mclk);
    rst_b <= 1'b0;
    repeat (20) @(negedge mclk);
    rst_b <= 1'b1;
  endtask : do_reset
  task automatic event_pulse(input logic [7:0] e);
    @(negedge mclk);
    ev <= e;
    @(negedge mclk);
    ev <= 8'h00;
  endtask : event_pulse
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_detect();
    check("mode after reset", {5'h0, mode}, 8'h00);
    i_hbap_host_model.init();
    check("mode after detect", {5'h0, mode}, 8'h03);
    i_hbap_host_model.dir_style = 1'b1;
    wr(3'h6, 8'h00);
    i_hbap_host_model.dir_style = 1'b0;
    check("mode frozen", {5'h0, mode}, 8'h03);
    $display("test_detect done");
  endtask : test_detect
  task automatic test_diagnostic_status_reg();
    event_pulse(8'h81);
    rd(HBAP_REG_DIAGNOSTIC_STATUS_REG, 2);
    check("diagnostic_status_reg data", q, 8'h81);
    check("diagnostic_status_reg clear", {7'h0, seen[2]}, 8'h01);
    rd(HBAP_REG_DIAGNOSTIC_STATUS_REG, 2);
    check("diagnostic_status_reg after clear", q, 8'h00);
    fork
      rd(HBAP_REG_NEXT_ID, 2);
      begin
        repeat (2) @(negedge mclk);
        check("oe during read", {7'h0, oe}, 8'h01);
      end
    join
    check("oe after read", {7'h0, oe}, 8'h00);
    check("next id", q, nid);
    check("next id pulse", {5'h0, seen}, 8'h01);
    $display("test_diagnostic_status_reg done");
  endtask : test_diagnostic_status_reg
  task automatic test_ram();
    wr(HBAP_REG_PTR_HI, 8'h40);
    wr(HBAP_REG_PTR_LO, 8'h10);
    wr(HBAP_REG_DATA, 8'hAA);
    wr(HBAP_REG_DATA, 8'hBB);
    wr(HBAP_REG_PTR_HI, 8'hC0);
    wr(HBAP_REG_PTR_LO, 8'h10);
    rd(HBAP_REG_DATA, 2);
    check("prefetch", q, 8'hAA);
    check("arb pulse", {5'h0, seen}, 8'h02);
    rd(HBAP_REG_DATA, 2);
    check("auto inc read", q, 8'hBB);
    wr(HBAP_REG_PTR_HI, 8'h80);
    wr(HBAP_REG_PTR_LO, 8'h11);
    rd(HBAP_REG_DATA, 2);
    check("fixed read", q, 8'hBB);
    // move the pointer high bits only: a refetch would now pick up an unwritten byte
    wr(HBAP_REG_PTR_HI, 8'h81);
    rd(HBAP_REG_DATA, 2);
    check("no refetch", q, 8'hBB);
    $display("test_ram done");
  endtask : test_ram
  task automatic test_timing();
    logic [2:0] rows [3];
    rows[0] = 3'b100;
    rows[1] = 3'b111;
    rows[2] = 3'b001;
    foreach (rows[i]) begin
      @(negedge mclk);
      pin <= rows[i][2];
      wr(HBAP_REG_CFG, {7'h0, rows[i][1]});
      event_pulse(8'h04);
      rd(HBAP_REG_DIAGNOSTIC_STATUS_REG, 2);
      check("short read clear", {7'h0, seen[2]}, {7'h0, !rows[i][0]});
      rd(HBAP_REG_DIAGNOSTIC_STATUS_REG, 4);
      check("fast read data", q, rows[i][0] ? 8'h04 : 8'h00);
      check("long read clear", {7'h0, seen[2]}, 8'h01);
    end
    @(negedge mclk);
    pin <= 1'b1;
    wr(HBAP_REG_CFG, 8'h00);
    $display("test_timing done");
  endtask : test_timing
  task automatic test_dir();
    do_reset();
    i_hbap_host_model.dir_style = 1'b1;
    fork
      wr(HBAP_REG_PTR_HI, 8'h00);
      begin
        repeat (2) @(negedge mclk);
        check("dir write oe", {7'h0, oe}, 8'h00);
      end
    join
    check("dir style", {5'h0, mode}, 8'h04);
    rd(HBAP_REG_DIAGNOSTIC_STATUS_REG, 2);
    check("dir muxed frozen", {5'h0, mode}, 8'h05);
    rd(HBAP_REG_NEXT_ID, 2);
    check("dir next id", q, nid);
    check("dir mode kept", {5'h0, mode}, 8'h05);
    $display("test_dir done");
  endtask : test_dir
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    pin = 1'b1;
    ev = 8'h00;
    nid = 8'h5A;
    bad_count = 0;
    n_compared = 0;
    do_reset();
    test_detect();
    test_diagnostic_status_reg();
    test_ram();
    test_timing();
    test_dir();
    finish_test();
  end
  initial begin
    #500000;
    bad_count++;
    $display("watchdog expired");
    finish_test();
  end
endmodule : hbap_port_tb_top
`default_nettype wire
